// ### src/cbt_pkg.sv
// Package of the CAN bit-timing and error-warning block: offsets, fields, resets.
// Assumes a single 10 MHz hclk domain and 32-bit AHB-Lite register access.
package cbt_pkg;
  // Register byte offsets
  localparam logic [7:0] CBT_OFF_MODE     = 8'h00;
  localparam logic [7:0] CBT_OFF_TIMING   = 8'h04;
  localparam logic [7:0] CBT_OFF_WARN     = 8'h08;
  localparam logic [7:0] CBT_OFF_STATUS   = 8'h0C;
  localparam logic [7:0] CBT_OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] CBT_OFF_IRQ_EN   = 8'h14;
  localparam logic [7:0] CBT_OFF_IRQ_CLR  = 8'h18;
  localparam logic [7:0] CBT_OFF_ERR_CNT  = 8'h1C;
  // Bit-timing fields
  localparam int unsigned CBT_TRIPLE_POS  = 23;
  localparam int unsigned CBT_SEG2_LSB    = 20;
  localparam int unsigned CBT_SEG1_LSB    = 16;
  localparam int unsigned CBT_SJW_LSB     = 14;
  localparam int unsigned CBT_PRESC_LSB   = 0;
  localparam logic [31:0] CBT_TIMING_MASK = 32'h00FFC3FF;
  // Reset values
  localparam logic        CBT_TRIPLE_RST  = 1'b0;
  localparam logic [2:0]  CBT_SEG2_RST    = 3'h1;
  localparam logic [3:0]  CBT_SEG1_RST    = 4'hC;
  localparam logic [1:0]  CBT_SJW_RST     = 2'h0;
  localparam logic [9:0]  CBT_PRESC_RST   = 10'h000;
  localparam logic [7:0]  CBT_WARN_RST    = 8'h60;
  localparam logic        CBT_MODE_RST    = 1'b1;
  // Transmit error count that means bus-off
  localparam logic [7:0]  CBT_BUS_OFF_CNT = 8'hFF;
  // Status byte layout, one byte per transmit buffer
  localparam int unsigned CBT_ST_BUS_OFF  = 7;
  localparam int unsigned CBT_ST_WARN     = 6;
  localparam int unsigned CBT_ST_TX_ACT   = 5;
  localparam int unsigned CBT_ST_RX_ACT   = 4;
  localparam int unsigned CBT_ST_TX_DONE  = 3;
  localparam int unsigned CBT_ST_TX_FREE  = 2;
  localparam int unsigned CBT_ST_OVERRUN  = 1;
  localparam int unsigned CBT_ST_RX_FULL  = 0;
  localparam int unsigned CBT_TX_BUFS     = 3;
  // Interrupt status bits
  localparam int unsigned CBT_IRQ_WARN_CHG = 0;
  localparam int unsigned CBT_IRQ_BUS_OFF  = 1;
  localparam int unsigned CBT_IRQ_BITS     = 2;
  // Bit-time layout in quanta
  localparam logic [5:0]  CBT_SYNC_TQ     = 6'h01;
endpackage

// ### src/cbt_core_if.sv
// Interface joining the register block with the bit timer and warning compare.
// Assumes all three modules sit on the same hclk.
`timescale 1ns/1ps
interface cbt_core_if;
  logic [9:0] prescaler;
  logic [3:0] seg1;
  logic [2:0] seg2;
  logic [1:0] sjw;
  logic       triple;
  logic       run;
  logic       rx_sync;
  logic       sample_pulse;
  logic       rx_bit;
  logic [7:0] tx_cnt;
  logic [7:0] rx_cnt;
  logic [7:0] threshold;
  logic       warn_flag;
  logic       bus_off_flag;
  logic       warn_change;
  modport top   (output prescaler, seg1, seg2, sjw, triple, run, rx_sync, tx_cnt, rx_cnt,
                 threshold, input sample_pulse, rx_bit, warn_flag, bus_off_flag, warn_change);
  modport timer (input prescaler, seg1, seg2, sjw, triple, run, rx_sync,
                 output sample_pulse, rx_bit);
  modport warn  (input tx_cnt, rx_cnt, threshold, run,
                 output warn_flag, bus_off_flag, warn_change);
endinterface // cbt_core_if

// ### src/cbt_bit_timer.sv
// Quantum prescaler and nominal bit timer with resynchronisation and sampling.
// Assumes rx_sync is already synchronised to hclk.
`timescale 1ns/1ps
module cbt_bit_timer (
  input wire logic hclk,
  input wire logic hresetn,
  cbt_core_if.timer tif
);
  import cbt_pkg::*;
  logic [9:0] q_cnt_q;
  logic [5:0] pos_q, sample_at_q, bit_end_q;
  logic [2:0] hist_q;
  logic       prev_q, resynced_q, sample_pulse_q, rx_bit_q;
  logic       tq, edge_seen, maj;
  logic [5:0] base_smp, base_end, jump, ext, early;

  assign tq        = tif.run && (q_cnt_q == tif.prescaler);
  assign base_smp  = {2'h0, tif.seg1} + CBT_SYNC_TQ;
  assign base_end  = base_smp + {3'h0, tif.seg2} + 6'h01;
  assign jump      = {4'h0, tif.sjw} + 6'h01;
  assign ext       = (pos_q < jump) ? pos_q : jump;
  assign early     = bit_end_q + 6'h01 - pos_q;
  assign edge_seen = tq && prev_q && !tif.rx_sync && !resynced_q && (pos_q != 6'h00);
  assign maj       = (hist_q[1] & hist_q[0]) | (hist_q[1] & tif.rx_sync) | (hist_q[0] & tif.rx_sync);
  assign tif.sample_pulse = sample_pulse_q;
  assign tif.rx_bit       = rx_bit_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) q_cnt_q <= 10'h000;
    else if (!tif.run || tq) q_cnt_q <= 10'h000;
    else q_cnt_q <= q_cnt_q + 10'h001;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos_q <= 6'h00; sample_at_q <= 6'h00; bit_end_q <= 6'h00; resynced_q <= 1'b0;
    end else if (!tif.run) begin
      pos_q <= 6'h00; sample_at_q <= base_smp; bit_end_q <= base_end; resynced_q <= 1'b0;
    end else if (tq) begin
      if (edge_seen && pos_q > sample_at_q && early <= jump) begin
        pos_q <= CBT_SYNC_TQ; sample_at_q <= base_smp; bit_end_q <= base_end;
        resynced_q <= 1'b0;
      end else if (pos_q >= bit_end_q) begin
        pos_q <= 6'h00; sample_at_q <= base_smp; bit_end_q <= base_end;
        resynced_q <= 1'b0;
      end else begin
        pos_q <= pos_q + 6'h01;
        if (edge_seen) begin
          resynced_q <= 1'b1;
          if (pos_q <= sample_at_q) begin
            sample_at_q <= sample_at_q + ext;
            bit_end_q   <= bit_end_q + ext;
          end else bit_end_q <= bit_end_q - jump;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hist_q <= 3'h7; prev_q <= 1'b1; sample_pulse_q <= 1'b0; rx_bit_q <= 1'b1;
    end else begin
      sample_pulse_q <= tq && (pos_q == sample_at_q);
      if (tq) begin
        hist_q <= {hist_q[1:0], tif.rx_sync};
        prev_q <= tif.rx_sync;
        if (pos_q == sample_at_q) rx_bit_q <= tif.triple ? maj : tif.rx_sync;
      end
    end
  end
endmodule // cbt_bit_timer

// ### src/cbt_warn_cmp.sv
// Error-warning compare and bus-off detection with change pulse.
// Assumes error counters come from logic on hclk.
`timescale 1ns/1ps
module cbt_warn_cmp (
  input wire logic hclk,
  input wire logic hresetn,
  cbt_core_if.warn wif
);
  import cbt_pkg::*;
  logic warn_q, bus_off_q, change_q, warn_d, bus_off_d;

  assign warn_d    = (wif.tx_cnt >= wif.threshold) || (wif.rx_cnt >= wif.threshold);
  assign bus_off_d = (wif.tx_cnt == CBT_BUS_OFF_CNT);
  assign wif.warn_flag    = warn_q;
  assign wif.bus_off_flag = bus_off_q;
  assign wif.warn_change  = change_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      warn_q <= 1'b0; bus_off_q <= 1'b0; change_q <= 1'b0;
    end else if (!wif.run) begin
      warn_q <= 1'b0; bus_off_q <= 1'b0; change_q <= 1'b0;
    end else begin
      warn_q    <= warn_d;
      bus_off_q <= bus_off_d;
      change_q  <= (warn_d != warn_q) || (bus_off_d != bus_off_q);
    end
  end
endmodule // cbt_warn_cmp

// ### src/cbt_top.sv
// Top of the CAN bit-timing and error-warning block with its AHB-Lite slave.
// Assumes one hclk domain; can_rx is an asynchronous pin, all other inputs are on hclk.
//
// Functional notes
// - Triple-sample bit set: majority of three samples
// - Triple-sample clear, reset value: one sample
// - After-sample segment is field plus one quanta
// - Before-sample segment is field plus one quanta
// - Jump width is field plus one quanta
// - Quantum lasts prescaler plus one clocks
// - Reserved bits read zero, software leaves them
// - Bit-timing writes only in soft-reset mode
// - Threshold writes only in soft-reset mode
// - Either counter reaching threshold sets warning
// - Controller status register is read-only
// - Status shows three buffers and controller
// - Warning flag reads one while threshold reached; the code holds it at zero in soft-reset mode
// - Enabled warning or bus-off change interrupts
//
// The implementer's own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module cbt_top
  import cbt_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        can_rx,
  input  wire logic [7:0]  tx_err_cnt,
  input  wire logic [7:0]  rx_err_cnt,
  input  wire logic [2:0]  tx_active,
  input  wire logic [2:0]  tx_done,
  input  wire logic [2:0]  tx_buf_free,
  input  wire logic        rx_active,
  input  wire logic        rx_buf_full,
  input  wire logic        data_overrun,
  output logic             irq,
  output logic             soft_reset_mode,
  output logic             sample_strobe,
  output logic             rx_bit,
  output logic             error_warning_flag,
  output logic             bus_off_flag
);
  import cbt_pkg::*;

  cbt_core_if core_if ();

  // Bus address phase capture
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic        addr_take;
  logic        hreadyout_q;
  logic [31:0] hrdata_q;
  logic        hresp_q;

  // Registers
  logic        soft_reset_q;
  logic        triple_q;
  logic [2:0]  seg2_q;
  logic [3:0]  seg1_q;
  logic [1:0]  sjw_q;
  logic [9:0]  presc_q;
  logic [7:0]  warn_thr_q;
  logic [CBT_IRQ_BITS-1:0] irq_stat_q;
  logic [CBT_IRQ_BITS-1:0] irq_stat_d;
  logic [CBT_IRQ_BITS-1:0] irq_en_q;
  logic [CBT_IRQ_BITS-1:0] irq_set;
  logic [CBT_IRQ_BITS-1:0] irq_clr;
  logic        irq_q;
  logic        bus_off_prev_q;

  // Pin synchroniser
  logic        rx_meta_q;
  logic        rx_sync_q;

  // Output flops
  logic        sample_strobe_q;
  logic        rx_bit_q;
  logic        warn_out_q;
  logic        bus_off_out_q;

  // Read path and write strobes
  logic [31:0] status_word;
  logic [31:0] timing_word;
  logic [31:0] rd_mux;
  logic        wr_mode;
  logic        wr_timing;
  logic        wr_warn;
  logic        wr_irq_en;
  logic        wr_irq_clr;
  logic        timing_we;
  logic        warn_we;

  assign addr_take = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (hready) begin
      wr_pend_q <= addr_take && hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  // Every transfer finishes with no wait state and an OKAY response
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end
  end

  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;
  assign hrdata    = hrdata_q;

  // Write strobes, taken in the data phase
  assign wr_mode    = wr_pend_q && (wr_addr_q == CBT_OFF_MODE);
  assign wr_timing  = wr_pend_q && (wr_addr_q == CBT_OFF_TIMING);
  assign wr_warn    = wr_pend_q && (wr_addr_q == CBT_OFF_WARN);
  assign wr_irq_en  = wr_pend_q && (wr_addr_q == CBT_OFF_IRQ_EN);
  assign wr_irq_clr = wr_pend_q && (wr_addr_q == CBT_OFF_IRQ_CLR);

  // Timing and threshold take writes only in soft-reset mode
  assign timing_we  = wr_timing && soft_reset_q;
  assign warn_we    = wr_warn && soft_reset_q;

  // Mode bit: high holds the controller in soft reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      soft_reset_q <= CBT_MODE_RST;
    end else if (wr_mode) begin
      soft_reset_q <= hwdata[0];
    end
  end

  // Sampling mode select
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      triple_q <= CBT_TRIPLE_RST;
    end else if (timing_we) begin
      triple_q <= hwdata[CBT_TRIPLE_POS];
    end
  end

  // Segment lengths around the sample point
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seg2_q <= CBT_SEG2_RST;
      seg1_q <= CBT_SEG1_RST;
    end else if (timing_we) begin
      seg2_q <= hwdata[CBT_SEG2_LSB +: 3];
      seg1_q <= hwdata[CBT_SEG1_LSB +: 4];
    end
  end

  // Resynchronisation jump width
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sjw_q <= CBT_SJW_RST;
    end else if (timing_we) begin
      sjw_q <= hwdata[CBT_SJW_LSB +: 2];
    end
  end

  // Quantum prescaler
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc_q <= CBT_PRESC_RST;
    end else if (timing_we) begin
      presc_q <= hwdata[CBT_PRESC_LSB +: 10];
    end
  end

  // Warning threshold
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      warn_thr_q <= CBT_WARN_RST;
    end else if (warn_we) begin
      warn_thr_q <= hwdata[7:0];
    end
  end

  // Interrupt enables
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_en_q <= '0;
    end else if (wr_irq_en) begin
      irq_en_q <= hwdata[CBT_IRQ_BITS-1:0];
    end
  end

  // Sticky event bits; a new event wins over a clear in the same cycle
  assign irq_set[CBT_IRQ_WARN_CHG] = core_if.warn_change;
  assign irq_set[CBT_IRQ_BUS_OFF]  = core_if.bus_off_flag && !bus_off_prev_q;
  assign irq_clr    = wr_irq_clr ? hwdata[CBT_IRQ_BITS-1:0] : '0;
  assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  // Previous bus-off level, for the entry edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_off_prev_q <= 1'b0;
    end else begin
      bus_off_prev_q <= core_if.bus_off_flag;
    end
  end

  // Level interrupt while any enabled event bit stands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_d & irq_en_q);
    end
  end

  assign irq = irq_q;

  // CAN receive pin passes two flops before any logic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= can_rx;
      rx_sync_q <= rx_meta_q;
    end
  end

  // Settings to the bit timer and warning compare
  assign core_if.prescaler = presc_q;
  assign core_if.seg1      = seg1_q;
  assign core_if.seg2      = seg2_q;
  assign core_if.sjw       = sjw_q;
  assign core_if.triple    = triple_q;
  assign core_if.run       = !soft_reset_q;
  assign core_if.rx_sync   = rx_sync_q;
  assign core_if.tx_cnt    = tx_err_cnt;
  assign core_if.rx_cnt    = rx_err_cnt;
  assign core_if.threshold = warn_thr_q;

  cbt_bit_timer u_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tif     (core_if.timer)
  );

  cbt_warn_cmp u_warn (
    .hclk    (hclk),
    .hresetn (hresetn),
    .wif     (core_if.warn)
  );

  // Status word, one byte per transmit buffer, controller bits repeated
  genvar gb;
  generate
    for (gb = 0; gb < CBT_TX_BUFS; gb++) begin : g_stat
      assign status_word[8*gb + CBT_ST_BUS_OFF] = core_if.bus_off_flag;
      assign status_word[8*gb + CBT_ST_WARN]    = core_if.warn_flag;
      assign status_word[8*gb + CBT_ST_TX_ACT]  = tx_active[gb];
      assign status_word[8*gb + CBT_ST_RX_ACT]  = rx_active;
      assign status_word[8*gb + CBT_ST_TX_DONE] = tx_done[gb];
      assign status_word[8*gb + CBT_ST_TX_FREE] = tx_buf_free[gb];
      assign status_word[8*gb + CBT_ST_OVERRUN] = data_overrun;
      assign status_word[8*gb + CBT_ST_RX_FULL] = rx_buf_full;
    end
  endgenerate
  assign status_word[31:24] = 8'h00;

  assign timing_word = ({8'h00, triple_q, seg2_q, seg1_q, sjw_q, 4'h0, presc_q})
                       & CBT_TIMING_MASK;

  always_comb begin
    rd_mux = 32'h00000000;
    case (haddr[7:0])
      CBT_OFF_MODE:     rd_mux = {31'h00000000, soft_reset_q};
      CBT_OFF_TIMING:   rd_mux = timing_word;
      CBT_OFF_WARN:     rd_mux = {24'h000000, warn_thr_q};
      CBT_OFF_STATUS:   rd_mux = status_word;
      CBT_OFF_IRQ_STAT: rd_mux = {30'h00000000, irq_stat_q};
      CBT_OFF_IRQ_EN:   rd_mux = {30'h00000000, irq_en_q};
      CBT_OFF_ERR_CNT:  rd_mux = {16'h0000, rx_err_cnt, tx_err_cnt};
      default:          rd_mux = 32'h00000000;
    endcase
  end

  // Read data is latched at the address phase and stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
    end else if (addr_take && !hwrite) begin
      hrdata_q <= rd_mux;
    end else if (hready) begin
      hrdata_q <= 32'h00000000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sample_strobe_q <= 1'b0;
      rx_bit_q        <= 1'b1;
    end else begin
      sample_strobe_q <= core_if.sample_pulse;
      rx_bit_q        <= core_if.rx_bit;
    end
  end

  // Flag outputs, one flop behind the compare
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      warn_out_q    <= 1'b0;
      bus_off_out_q <= 1'b0;
    end else begin
      warn_out_q    <= core_if.warn_flag;
      bus_off_out_q <= core_if.bus_off_flag;
    end
  end

  assign soft_reset_mode    = soft_reset_q;
  assign sample_strobe      = sample_strobe_q;
  assign rx_bit             = rx_bit_q;
  assign error_warning_flag = warn_out_q;
  assign bus_off_flag       = bus_off_out_q;
endmodule // cbt_top

// ### dv/cbt_top_sva.sv
// Port-level assertions for the bit-timing and warning block.
// Assumes binding to cbt_top on a single hclk domain.
`timescale 1ns/1ps
module cbt_top_sva
  import cbt_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic [7:0]  tx_err_cnt,
  input wire logic        soft_reset_mode,
  input wire logic        sample_strobe,
  input wire logic        rx_bit,
  input wire logic        error_warning_flag,
  input wire logic        bus_off_flag
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic       rd_q;
  logic [7:0] ad_q;
  // Marks the data phase of a read and its offset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= 1'b0;
      ad_q <= 8'h00;
    end else if (hready) begin
      rd_q <= hsel && htrans[1] && !hwrite;
      ad_q <= haddr[7:0];
    end
  end
  ready_high_a: assert property (hreadyout && !hresp)
    else $error("slave not ready or not okay");
  rdata_idle_a: assert property (!rd_q |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  timing_resv_a: assert property (rd_q && ad_q == CBT_OFF_TIMING |->
    (hrdata & ~CBT_TIMING_MASK) == 32'h0) else $error("timing reserved bits set");
  warn_resv_a: assert property (rd_q && ad_q == CBT_OFF_WARN |->
    hrdata[31:8] == 24'h0) else $error("threshold reserved bits set");
  bus_off_a: assert property ((!soft_reset_mode && tx_err_cnt == CBT_BUS_OFF_CNT)[*3]
    |-> bus_off_flag && error_warning_flag) else $error("full counter gave no flags");
  quiet_mode_a: assert property (soft_reset_mode[*4] |->
    !sample_strobe && !error_warning_flag && !bus_off_flag) else $error("activity in reset mode");
  strobe_gap_a: assert property (sample_strobe |=> !sample_strobe)
    else $error("sample strobes adjacent");
  rxbit_hold_a: assert property ($changed(rx_bit) |->
    $past(sample_strobe) or (##[0:3] sample_strobe)) else $error("rx bit moved off sample");
  cover property (bus_off_flag);
  cover property (sample_strobe && !rx_bit);
  cover property (rd_q && ad_q == CBT_OFF_STATUS);
endmodule // cbt_top_sva

bind cbt_top cbt_top_sva u_sva (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .hrdata, .tx_err_cnt, .soft_reset_mode, .sample_strobe, .rx_bit,
  .error_warning_flag, .bus_off_flag);

// ### dv/cbt_can_node.sv
// Other node on the CAN bus: sends a 16-bit pattern MSB first on go.
// Assumes a fixed bit length in hclk cycles; idle bus is recessive.
`timescale 1ns/1ps
module cbt_can_node (
  input  wire logic        hclk,
  input  wire logic        go,
  input  wire logic [15:0] bits,
  input  wire logic [7:0]  bit_clks,
  output logic             can_rx
);
  logic [15:0] sh_q = 16'hFFFF;
  logic [4:0]  left_q = 5'h00;
  logic [7:0]  cnt_q = 8'h00;
  always_ff @(posedge hclk) begin
    if (go) begin
      sh_q   <= bits;
      left_q <= 5'h10;
      cnt_q  <= 8'h00;
    end else if (left_q != 5'h00) begin
      cnt_q <= (cnt_q == bit_clks - 8'h01) ? 8'h00 : cnt_q + 8'h01;
      if (cnt_q == bit_clks - 8'h01) begin
        sh_q   <= sh_q << 1;
        left_q <= left_q - 5'h01;
      end
    end
  end
  // Released bus is pulled recessive by the wired-and
  assign can_rx = (left_q != 5'h00) ? sh_q[15] : 1'b1;
endmodule // cbt_can_node

// ### dv/can_bit_timing_and_warning_tb.sv
// Self-checking bench for cbt_top: AHB-Lite master, status inputs, CAN node.
// Assumes a 10 MHz hclk and zero-wait AHB-Lite slave.
`timescale 1ns/1ps
module can_bit_timing_and_warning_tb;
  import cbt_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] v;} cbt_row_t;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, d, n;
  logic [1:0]  htrans;
  logic [2:0]  hsize, tx_active, tx_done, tx_buf_free;
  logic [7:0]  tx_err_cnt, rx_err_cnt;
  logic        can_rx, rx_active, rx_buf_full, data_overrun, soft_reset_mode;
  logic        sample_strobe, rx_bit, error_warning_flag, bus_off_flag, go;
  logic [15:0] bits;
  logic [7:0]  bit_clks;
  int          fail_count = 0, checked = 0, cyc = 0;
  cbt_row_t    rows [9] = '{'{8'h00, 32'h1}, '{8'h04, 32'h001C0000}, '{8'h08, 32'h60},
    '{8'h0C, 32'h0}, '{8'h10, 32'h0}, '{8'h14, 32'h0}, '{8'h18, 32'h0}, '{8'h1C, 32'h0},
    '{8'h24, 32'h0}};
  assign hready = hreadyout;
  cbt_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .can_rx, .tx_err_cnt, .rx_err_cnt, .tx_active, .tx_done,
    .tx_buf_free, .rx_active, .rx_buf_full, .data_overrun, .irq, .soft_reset_mode,
    .sample_strobe, .rx_bit, .error_warning_flag, .bus_off_flag);
  cbt_can_node u_node (.hclk, .go, .bits, .bit_clks, .can_rx);
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    d = hrdata;
  endtask
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, go, bits} = '0;
    {tx_err_cnt, rx_err_cnt, tx_active, tx_done, tx_buf_free} = '0;
    {rx_active, rx_buf_full, data_overrun} = '0;
    hsize = 3'h2;
    bit_clks = 8'h0C;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (rows[i]) begin
      bus(1'b0, rows[i].a, 32'h0);
      chk("reset value", d, rows[i].v);
    end
    $display("reset values done");
    bus(1'b1, CBT_OFF_TIMING, 32'hFFFFFFFF);
    bus(1'b0, CBT_OFF_TIMING, 32'h0);
    chk("timing fields", d, CBT_TIMING_MASK);
    bus(1'b1, CBT_OFF_WARN, 32'hFFFFFF55);
    bus(1'b0, CBT_OFF_WARN, 32'h0);
    chk("threshold", d, 32'h55);
    bus(1'b1, CBT_OFF_MODE, 32'h0);
    bus(1'b1, CBT_OFF_TIMING, 32'h0);
    bus(1'b1, CBT_OFF_WARN, 32'h0);
    bus(1'b0, CBT_OFF_TIMING, 32'h0);
    chk("timing locked", d, CBT_TIMING_MASK);
    bus(1'b0, CBT_OFF_WARN, 32'h0);
    chk("threshold locked", d, 32'h55);
    $display("write lock done");
    for (int t = 0; t < 2; t++) begin
      bus(1'b1, CBT_OFF_MODE, 32'h1);
      bus(1'b1, CBT_OFF_TIMING, {8'h00, t[0], 3'h1, 4'h2, 1'b0, t[0], 4'h0, 10'h001});
      bus(1'b1, CBT_OFF_MODE, 32'h0);
      n = 0;
      while (sample_strobe !== 1'b1) @(posedge hclk);
      @(posedge hclk);
      while (sample_strobe !== 1'b1) begin
        n++;
        @(posedge hclk);
      end
      chk("bit length", n + 1, 32'h0000000C);
      bits <= t ? 16'h7FFF : 16'h0FFF;
      go   <= 1'b1;
      @(posedge hclk);
      go <= 1'b0;
      n = 0;
      repeat (150) begin
        @(posedge hclk);
        if (rx_bit === 1'b0) n = 1;
      end
      chk("dominant sampled", n, 32'h1);
      repeat (150) @(posedge hclk);
      chk("recessive sampled", rx_bit, 32'h1);
      // One-quantum dominant spikes, never two in any three quanta: the vote rejects them
      if (t == 1) begin
        bit_clks <= 8'h02;
        bits     <= 16'h6DB6;
        go       <= 1'b1;
        @(posedge hclk);
        go <= 1'b0;
        n = 0;
        repeat (60) begin
          @(posedge hclk);
          if (rx_bit === 1'b0) n = 1;
        end
        chk("spike filtered", n, 32'h0);
      end
      $display("sampling mode %0d done", t);
    end
    tx_active <= 3'b101;
    tx_done <= 3'b001;
    tx_buf_free <= 3'b010;
    {rx_active, rx_buf_full, data_overrun} <= 3'b111;
    bus(1'b1, CBT_OFF_IRQ_EN, 32'h1);
    tx_err_cnt <= 8'h55;
    repeat (5) @(posedge hclk);
    chk("warn flag", error_warning_flag, 32'h1);
    chk("irq raised", irq, 32'h1);
    bus(1'b0, CBT_OFF_STATUS, 32'h0);
    chk("status", d, 32'h0073577B);
    bus(1'b1, CBT_OFF_STATUS, 32'hFFFFFFFF);
    bus(1'b0, CBT_OFF_STATUS, 32'h0);
    chk("status read-only", d, 32'h0073577B);
    bus(1'b1, CBT_OFF_IRQ_CLR, 32'h1);
    repeat (3) @(posedge hclk);
    chk("irq cleared", irq, 32'h0);
    bus(1'b1, CBT_OFF_IRQ_EN, 32'h0);
    tx_err_cnt <= 8'h54;
    rx_err_cnt <= 8'h55;
    repeat (5) @(posedge hclk);
    chk("rx warn", error_warning_flag, 32'h1);
    rx_err_cnt <= 8'h00;
    repeat (5) @(posedge hclk);
    chk("warn gone", error_warning_flag, 32'h0);
    chk("irq masked", irq, 32'h0);
    bus(1'b0, CBT_OFF_IRQ_STAT, 32'h0);
    chk("change seen", d[0], 32'h1);
    bus(1'b0, CBT_OFF_ERR_CNT, 32'h0);
    chk("counters", d, 32'h00000054);
    tx_err_cnt <= 8'hFF;
    repeat (5) @(posedge hclk);
    chk("bus off", bus_off_flag, 32'h1);
    bus(1'b0, CBT_OFF_STATUS, 32'h0);
    chk("status bus off", d[23:22], 32'h3);
    $display("warning done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, CBT_OFF_TIMING, 32'h0);
    chk("timing after reset", d, 32'h001C0000);
    $display("second reset done");
    wrap_up();
  end
endmodule // can_bit_timing_and_warning_tb
